// >>> hdl/safe_torque_off_logic.sv
// Two-channel safe torque-off logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module safe_torque_off_logic #(
  parameter int NUM_AXES   = 8,
  parameter int CYC_PER_MS = sto_pkg::CYC_PER_MS,
  parameter int ADDR_W     = 8
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic                req1_chan_a,
  input  wire logic                req1_chan_b,
  input  wire logic                req1_ack,
  input  wire logic                req2_chan_a,
  input  wire logic                req2_chan_b,
  input  wire logic                req2_ack,
  input  wire logic                req3_chan_a,
  input  wire logic                req3_chan_b,
  input  wire logic                mode_sel_0,
  input  wire logic                mode_sel_1,
  input  wire logic [NUM_AXES-1:0] torque_fb_a,
  input  wire logic [NUM_AXES-1:0] torque_fb_b,
  output logic [NUM_AXES-1:0]      torque_off_chan_a,
  output logic [NUM_AXES-1:0]      torque_off_chan_b,
  output logic                     req1_status,
  output logic                     req2_status,
  output logic                     req3_status,
  output logic                     fault,
  output logic                     irq
);
  localparam int NPIN    = 10;
  localparam int MON_CYC = sto_pkg::MON_TIME_MS * CYC_PER_MS;
  localparam int MON_W   = $clog2(MON_CYC + 1);
  localparam int TW      = sto_pkg::TMR_W;
  localparam logic [MON_W-1:0] MON_LAST = MON_W'(MON_CYC - 1);
  localparam logic [2:0]       SU_LAST  = 3'(sto_pkg::STARTUP_CYC - 1);

  // Pin synchronisers
  logic [NPIN-1:0]                 pin_s1_q;
  logic [NPIN-1:0]                 pin_s2_q;
  logic [1:0][NUM_AXES-1:0]        fb_s1_q;
  logic [1:0][NUM_AXES-1:0]        fb_s2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      fb_s1_q  <= '0;
      fb_s2_q  <= '0;
    end else begin
      pin_s1_q <= {mode_sel_1, mode_sel_0, req3_chan_b, req3_chan_a, req2_ack,
                   req2_chan_b, req2_chan_a, req1_ack, req1_chan_b, req1_chan_a};
      pin_s2_q <= pin_s1_q;
      fb_s1_q  <= {torque_fb_b, torque_fb_a};
      fb_s2_q  <= fb_s1_q;
    end
  end

  logic [1:0][1:0] req_v;
  logic [1:0]      ack_v;
  logic [1:0]      req3;
  logic            mode_hi;
  logic [1:0]      act_v;

  assign req_v[0] = pin_s2_q[1:0];
  assign req_v[1] = pin_s2_q[4:3];
  assign ack_v    = {pin_s2_q[5], pin_s2_q[2]};
  assign req3     = pin_s2_q[7:6];
  assign mode_hi  = pin_s2_q[8] | pin_s2_q[9];
  assign act_v    = {~mode_hi, 1'b1};

  // Register state
  logic [sto_pkg::SEL_W-1:0] ss1_sel_q;
  logic [sto_pkg::SEL_W-1:0] ss1_sel_d;
  logic [sto_pkg::EV_W-1:0]  irq_st_q;
  logic [sto_pkg::EV_W-1:0]  irq_st_d;
  logic [sto_pkg::EV_W-1:0]  irq_en_q;
  logic [sto_pkg::EV_W-1:0]  irq_en_d;
  logic [sto_pkg::EV_W-1:0]  ev;

  // Delay timers, one per channel of requests 1 and 2
  logic [1:0][1:0] t_start;
  logic [1:0][1:0] t_busy;
  logic [1:0][1:0] t_done;
  logic [TW-1:0]   ss1_load;
  logic            ss1_zero;

  assign ss1_load = TW'(sto_pkg::ss1_ms(ss1_sel_q) * CYC_PER_MS);
  assign ss1_zero = (sto_pkg::ss1_ms(ss1_sel_q) == 0);

  for (genvar r = 0; r < 2; r++) begin : g_req
    for (genvar c = 0; c < 2; c++) begin : g_chan
      ss1_delay_timer #(.W(TW)) u_tmr (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (t_start[r][c]),
        .load    (ss1_load),
        .busy    (t_busy[r][c]),
        .done    (t_done[r][c])
      );
    end
  end

  // Safety state
  logic            up_q;
  logic            up_d;
  logic [2:0]      su_q;
  logic [2:0]      su_d;
  logic [1:0]      lat_q;
  logic [1:0]      lat_d;
  logic [1:0]      bl_q;
  logic [1:0]      bl_d;
  logic [1:0][1:0] off_q;
  logic [1:0][1:0] off_d;
  logic            lat3_q;
  logic            lat3_d;
  logic            bl3_q;
  logic            bl3_d;
  logic [1:0]      off3_q;
  logic [1:0]      off3_d;
  logic [1:0]      ack_prev_q;
  logic [1:0]      ack_fall;
  logic [1:0]      to_q;
  logic [1:0]      to_d;
  logic            fault_q;
  logic            fault_d;

  assign ack_fall = ack_prev_q & ~ack_v;

  always_comb begin
    up_d    = up_q;
    su_d    = su_q;
    lat_d   = lat_q;
    bl_d    = bl_q;
    off_d   = off_q;
    lat3_d  = lat3_q;
    bl3_d   = bl3_q;
    off3_d  = off3_q;
    t_start = '0;
    if (!up_q) begin
      su_d = su_q + 3'h1;
      // Inputs sampled once settled; high ones release without ack
      if (su_q == SU_LAST) begin
        up_d = 1'b1;
        for (int r = 0; r < 2; r++) begin
          lat_d[r] = act_v[r] & ~(&req_v[r]);
          bl_d[r]  = act_v[r] & ~(|req_v[r]);
          off_d[r] = act_v[r] ? ~req_v[r] : 2'h0;
        end
        lat3_d = mode_hi & ~(&req3);
        bl3_d  = mode_hi & ~(|req3);
        off3_d = mode_hi ? ~req3 : 2'h0;
      end
    end else begin
      for (int r = 0; r < 2; r++) begin
        if (act_v[r] && !(&req_v[r])) begin
          lat_d[r] = 1'b1;
        end
        if (act_v[r] && !(|req_v[r])) begin
          bl_d[r] = 1'b1;
        end
        for (int c = 0; c < 2; c++) begin
          if (act_v[r] && !req_v[r][c] && !off_q[r][c] &&
              !t_busy[r][c] && !t_done[r][c]) begin
            if (ss1_zero) begin
              off_d[r][c] = 1'b1;
            end else begin
              t_start[r][c] = 1'b1;
            end
          end
          if (t_done[r][c]) begin
            off_d[r][c] = 1'b1;
          end
        end
        if (lat_q[r] && bl_q[r] && (&req_v[r]) && ack_fall[r] && !(|t_busy[r])) begin
          lat_d[r] = 1'b0;
          bl_d[r]  = 1'b0;
          off_d[r] = 2'h0;
        end
      end
      if (mode_hi) begin
        if (!(&req3)) begin
          lat3_d = 1'b1;
        end
        if (!(|req3)) begin
          bl3_d = 1'b1;
        end
        off3_d = off3_q | ~req3;
      end
      if (lat3_q && bl3_q && (&req3)) begin
        lat3_d = 1'b0;
        bl3_d  = 1'b0;
        off3_d = 2'h0;
      end
    end
    for (int c = 0; c < 2; c++) begin
      to_d[c] = up_q & ~fault_q & ~off_q[0][c] & ~off_q[1][c] & ~off3_q[c];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q       <= 1'b0;
      su_q       <= 3'h0;
      lat_q      <= 2'h0;
      bl_q       <= 2'h0;
      off_q      <= '0;
      lat3_q     <= 1'b0;
      bl3_q      <= 1'b0;
      off3_q     <= 2'h0;
      ack_prev_q <= 2'h0;
      to_q       <= 2'h0;
    end else begin
      up_q       <= up_d;
      su_q       <= su_d;
      lat_q      <= lat_d;
      bl_q       <= bl_d;
      off_q      <= off_d;
      lat3_q     <= lat3_d;
      bl3_q      <= bl3_d;
      off3_q     <= off3_d;
      ack_prev_q <= ack_v;
      to_q       <= to_d;
    end
  end

  // Output feedback monitor
  logic [1:0][MON_W-1:0] mon_q;
  logic [1:0][MON_W-1:0] mon_d;
  logic [1:0]            mis;

  always_comb begin
    fault_d = fault_q;
    for (int c = 0; c < 2; c++) begin
      mis[c]   = (fb_s2_q[c] != {NUM_AXES{to_q[c]}});
      mon_d[c] = '0;
      if (mis[c]) begin
        mon_d[c] = (mon_q[c] == MON_LAST) ? mon_q[c] : mon_q[c] + MON_W'(1);
        if (mon_q[c] == MON_LAST) begin
          fault_d = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_q   <= '0;
      fault_q <= 1'b0;
    end else begin
      mon_q   <= mon_d;
      fault_q <= fault_d;
    end
  end

  assign torque_off_chan_a = {NUM_AXES{to_q[0]}};
  assign torque_off_chan_b = {NUM_AXES{to_q[1]}};
  assign req1_status       = up_q & ~lat_q[0];
  assign req2_status       = up_q & ~lat_q[1];
  assign req3_status       = up_q & ~lat3_q;
  assign fault             = fault_q;
  assign irq               = |(irq_st_q & irq_en_q);

  assign ev[sto_pkg::EV_REQ1]  = lat_d[0] & ~lat_q[0];
  assign ev[sto_pkg::EV_REQ2]  = lat_d[1] & ~lat_q[1];
  assign ev[sto_pkg::EV_REQ3]  = lat3_d & ~lat3_q;
  assign ev[sto_pkg::EV_FAULT] = fault_d & ~fault_q;

  // AXI4-Lite slave
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(sto_pkg::ADDR_CTRL) || a == ADDR_W'(sto_pkg::ADDR_STATE) ||
           a == ADDR_W'(sto_pkg::ADDR_IRQ_STAT) || a == ADDR_W'(sto_pkg::ADDR_IRQ_EN) ||
           a == ADDR_W'(sto_pkg::ADDR_IRQ_CLR);
  endfunction : addr_ok

  logic              aw_full_q;
  logic              aw_full_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [ADDR_W-1:0] aw_addr_d;
  logic              w_full_q;
  logic              w_full_d;
  logic [31:0]       w_data_q;
  logic [31:0]       w_data_d;
  logic              w_b0_q;
  logic              w_b0_d;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;
  logic [1:0]        bresp_d;
  logic              rvalid_q;
  logic              rvalid_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic [1:0]        rresp_q;
  logic [1:0]        rresp_d;
  logic [31:0]       st_word;
  logic [sto_pkg::EV_W-1:0] clr;

  always_comb begin
    st_word                    = '0;
    st_word[sto_pkg::ST_REQ1]  = req1_status;
    st_word[sto_pkg::ST_REQ2]  = req2_status;
    st_word[sto_pkg::ST_REQ3]  = req3_status;
    st_word[sto_pkg::ST_TO_A]  = to_q[0];
    st_word[sto_pkg::ST_TO_B]  = to_q[1];
    st_word[sto_pkg::ST_FAULT] = fault_q;
    st_word[sto_pkg::ST_MODE]  = mode_hi;
    st_word[sto_pkg::ST_UP]    = up_q;
  end

  assign awready = ~aw_full_q & ~bvalid_q;
  assign wready  = ~w_full_q & ~bvalid_q;
  assign arready = ~rvalid_q;

  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_b0_d    = w_b0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    ss1_sel_d = ss1_sel_q;
    irq_en_d  = irq_en_q;
    clr       = '0;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      w_data_d = wdata;
      w_b0_d   = wstrb[0];
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = addr_ok(aw_addr_q) ? sto_pkg::RESP_OKAY : sto_pkg::RESP_SLVERR;
      if (w_b0_q) begin
        if (aw_addr_q == ADDR_W'(sto_pkg::ADDR_CTRL)) begin
          ss1_sel_d = w_data_q[sto_pkg::SEL_W-1:0];
        end
        if (aw_addr_q == ADDR_W'(sto_pkg::ADDR_IRQ_EN)) begin
          irq_en_d = w_data_q[sto_pkg::EV_W-1:0];
        end
        if (aw_addr_q == ADDR_W'(sto_pkg::ADDR_IRQ_CLR)) begin
          clr = w_data_q[sto_pkg::EV_W-1:0];
        end
      end
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = addr_ok(araddr) ? sto_pkg::RESP_OKAY : sto_pkg::RESP_SLVERR;
      rdata_d  = '0;
      if (araddr == ADDR_W'(sto_pkg::ADDR_CTRL)) begin
        rdata_d[sto_pkg::SEL_W-1:0] = ss1_sel_q;
      end
      if (araddr == ADDR_W'(sto_pkg::ADDR_STATE)) begin
        rdata_d = st_word;
      end
      if (araddr == ADDR_W'(sto_pkg::ADDR_IRQ_STAT)) begin
        rdata_d[sto_pkg::EV_W-1:0] = irq_st_q;
      end
      if (araddr == ADDR_W'(sto_pkg::ADDR_IRQ_EN)) begin
        rdata_d[sto_pkg::EV_W-1:0] = irq_en_q;
      end
    end
    // A new event beats a clear in the same cycle
    irq_st_d = (irq_st_q & ~clr) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_data_q  <= '0;
      w_b0_q    <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sto_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= sto_pkg::RESP_OKAY;
      ss1_sel_q <= sto_pkg::CTRL_RST;
      irq_en_q  <= sto_pkg::IRQ_EN_RST;
      irq_st_q  <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_b0_q    <= w_b0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      ss1_sel_q <= ss1_sel_d;
      irq_en_q  <= irq_en_d;
      irq_st_q  <= irq_st_d;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp  = bresp_q;
  assign rvalid = rvalid_q;
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_run_quiet;
    up_q && !fault_q && lat_q == 2'h0 && !lat3_q && (&req_v[0]) && (&req_v[1]) && !mode_hi;
  endsequence
  sequence s_req3_drop;
    up_q && mode_hi && !req3[0] && !fault_q;
  endsequence

  a_run_all_on: assert property (s_run_quiet [*2] |=> to_q == 2'h3)
    else $error("torque not on with all requests high");
  a_req1_status: assert property ((up_q && !(&req_v[0])) |=> !req1_status)
    else $error("status 1 did not drop");
  a_req2_mode: assert property ($rose(lat_q[1]) |-> $past(!mode_hi))
    else $error("second request acted outside mode 0");
  a_ack_restore: assert property ($fell(lat_q[0]) |-> $past(ack_fall[0]))
    else $error("first request left without ack edge");
  a_req3_cut: assert property (s_req3_drop |=> off3_q[0] ##1 !to_q[0])
    else $error("third request did not cut channel a");
  a_req3_restore: assert property ((lat3_q && bl3_q && (&req3)) |=> !lat3_q)
    else $error("third request did not restore");
  // Timer end is flagged one edge before the channel is cut
  a_delay_holds: assert property (t_busy[0][0] |=> t_busy[0][0] or
    (t_done[0][0] ##1 off_q[0][0]))
    else $error("delayed stop was cancelled");
  a_early_cut: assert property ($rose(off_q[0][0]) |->
    $past(ss1_zero) || $past(t_done[0][0]) || $past(!up_q))
    else $error("channel cut before delay ended");
  a_start_release: assert property (($rose(up_q) && !fault_q &&
    lat_q == 2'h0 && !lat3_q) |-> req1_status ##1 to_q == 2'h3)
    else $error("start-up did not release torque");
  a_fault_latch: assert property ((mis[0] && mon_q[0] == MON_LAST) |=>
    fault_q ##1 to_q == 2'h0)
    else $error("feedback mismatch not faulted");
  a_set_wins: assert property ((ev[0] && clr[0]) |=> irq_st_q[0])
    else $error("event lost under clear");
endmodule : safe_torque_off_logic
`default_nettype wire

// >>> common/sto_pkg.sv
// Constants, register map and delay table of the safe torque-off logic
package sto_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int MON_TIME_MS   = 1;
  localparam int STARTUP_CYC   = 4;
  localparam int TMR_W         = 26;
  localparam int SEL_W         = 3;
  localparam int EV_W          = 4;

  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STATE    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h10;

  localparam logic [SEL_W-1:0] CTRL_RST   = 3'h0;
  localparam logic [EV_W-1:0]  IRQ_EN_RST = 4'h0;

  localparam int ST_REQ1  = 0;
  localparam int ST_REQ2  = 1;
  localparam int ST_REQ3  = 2;
  localparam int ST_TO_A  = 3;
  localparam int ST_TO_B  = 4;
  localparam int ST_FAULT = 5;
  localparam int ST_MODE  = 6;
  localparam int ST_UP    = 7;

  localparam int EV_REQ1  = 0;
  localparam int EV_REQ2  = 1;
  localparam int EV_REQ3  = 2;
  localparam int EV_FAULT = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Delayed-stop time in ms for each selector code
  function automatic int ss1_ms(input logic [SEL_W-1:0] sel);
    case (sel)
      3'h0: return 0;
      3'h1: return 200;
      3'h2: return 300;
      3'h3: return 400;
      3'h4: return 500;
      3'h5: return 600;
      3'h6: return 800;
      default: return 1000;
    endcase
  endfunction : ss1_ms
endpackage : sto_pkg

// >>> hdl/ss1_delay_timer.sv
// Down-counter that times one delayed-stop interval
`timescale 1ns/1ps
`default_nettype none
module ss1_delay_timer #(
  parameter int W = 26
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         busy_q;
  logic         busy_d;
  logic         done_q;
  logic         done_d;

  // Once loaded it runs out unless start loads it again
  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d  = load;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= W'(1)) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
endmodule : ss1_delay_timer
`default_nettype wire

// >>> verif/sto_drive_model.sv
// Drive-side model: torque-off inputs of the axes reporting their level
`timescale 1ns/1ps
`default_nettype none
module sto_drive_model #(
  parameter int N = 8
) (
  input  wire logic [N-1:0] torque_off_chan_a,
  input  wire logic [N-1:0] torque_off_chan_b,
  input  wire logic         stuck,
  output logic [N-1:0]      torque_fb_a,
  output logic [N-1:0]      torque_fb_b
);
  // A broken stage reports the opposite level
  assign torque_fb_a = stuck ? ~torque_off_chan_a : torque_off_chan_a;
  assign torque_fb_b = stuck ? ~torque_off_chan_b : torque_off_chan_b;
endmodule : sto_drive_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking testbench of the safe torque-off logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); end end
module testbench;
  localparam int CPM = 10;
  logic [7:0]  awaddr, araddr, torque_fb_a, torque_fb_b, to_a, to_b;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, stuck, fault, irq, mode_sel_0, mode_sel_1;
  logic req1_chan_a, req1_chan_b, req1_ack, req2_chan_a, req2_chan_b, req2_ack;
  logic req3_chan_a, req3_chan_b, req1_status, req2_status, req3_status;
  int n_fail = 0;
  int checked = 0;
  int ss1_tab [8] = '{0, 200, 300, 400, 500, 600, 800, 1000};

  safe_torque_off_logic #(.CYC_PER_MS(CPM)) u_dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .req1_chan_a, .req1_chan_b, .req1_ack,
    .req2_chan_a, .req2_chan_b, .req2_ack, .req3_chan_a, .req3_chan_b, .mode_sel_0,
    .mode_sel_1, .torque_fb_a, .torque_fb_b, .torque_off_chan_a(to_a),
    .torque_off_chan_b(to_b), .req1_status, .req2_status, .req3_status, .fault, .irq);
  sto_drive_model #(.N(8)) u_drive (.torque_off_chan_a(to_a), .torque_off_chan_b(to_b),
    .stuck, .torque_fb_a, .torque_fb_b);

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    `CHK({bvalid, bresp}, {1'b1, er})
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    `CHK({rvalid, rresp, rdata}, {1'b1, er, ed})
  endtask : rd

  task automatic t_startup;
    cyc(10);
    `CHK({to_a, to_b, req1_status, req2_status}, {16'hFFFF, 2'h3})
    rd(sto_pkg::ADDR_CTRL, 32'h0, sto_pkg::RESP_OKAY);
    rd(sto_pkg::ADDR_IRQ_EN, 32'h0, sto_pkg::RESP_OKAY);
    rd(sto_pkg::ADDR_STATE, 32'h9F, sto_pkg::RESP_OKAY);
    rd(8'h14, 32'h0, sto_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, sto_pkg::RESP_SLVERR);
    wr(sto_pkg::ADDR_IRQ_EN, 32'hF, sto_pkg::RESP_OKAY);
  endtask : t_startup

  task automatic t_req1(input int sel);
    int ms;
    ms = ss1_tab[sel];
    wr(sto_pkg::ADDR_CTRL, sel, sto_pkg::RESP_OKAY);
    @(posedge aclk);
    req1_chan_a <= 1'b0;
    cyc(4);
    `CHK(req1_status, 1'b0)
    if (ms > 0) begin
      // Input returns high halfway, the stop must still complete
      cyc(ms * CPM / 2);
      req1_chan_a <= 1'b1;
      cyc(ms * CPM / 2 - 15);
      `CHK(to_a, 8'hFF)
    end
    cyc(30);
    `CHK({to_a, to_b, irq}, {8'h00, 8'hFF, 1'b1})
    wr(sto_pkg::ADDR_CTRL, 32'h0, sto_pkg::RESP_OKAY);
    wr(sto_pkg::ADDR_IRQ_CLR, 32'h1, sto_pkg::RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b0)
    req1_chan_a <= 1'b0;
    req1_chan_b <= 1'b0;
    cyc(5);
    req1_chan_a <= 1'b1;
    req1_chan_b <= 1'b1;
    cyc(10);
    `CHK({to_a, req1_status}, 9'h000)
    req1_ack <= 1'b0;
    cyc(10);
    `CHK({to_a, to_b, req1_status}, {16'hFFFF, 1'b1})
    req1_ack <= 1'b1;
  endtask : t_req1

  task automatic t_req2;
    wr(sto_pkg::ADDR_IRQ_EN, 32'h0, sto_pkg::RESP_OKAY);
    wr(sto_pkg::ADDR_CTRL, 32'h1, sto_pkg::RESP_OKAY);
    @(posedge aclk);
    req2_chan_b <= 1'b0;
    cyc(4);
    `CHK(req2_status, 1'b0)
    cyc(200 * CPM - 15);
    `CHK(to_b, 8'hFF)
    cyc(30);
    `CHK({to_b, to_a, irq}, {8'h00, 8'hFF, 1'b0})
    rd(sto_pkg::ADDR_IRQ_STAT, 32'h2, sto_pkg::RESP_OKAY);
    wr(sto_pkg::ADDR_IRQ_CLR, 32'h2, sto_pkg::RESP_OKAY);
    wr(sto_pkg::ADDR_CTRL, 32'h0, sto_pkg::RESP_OKAY);
    req2_chan_a <= 1'b0;
    cyc(5);
    req2_chan_a <= 1'b1;
    req2_chan_b <= 1'b1;
    cyc(10);
    req2_ack <= 1'b0;
    cyc(10);
    `CHK({to_b, req2_status}, {8'hFF, 1'b1})
    req2_ack <= 1'b1;
  endtask : t_req2

  task automatic t_req3;
    @(posedge aclk);
    mode_sel_0 <= 1'b1;
    cyc(4);
    req3_chan_b <= 1'b0;
    req2_chan_a <= 1'b0;
    cyc(8);
    `CHK({req3_status, req2_status, to_b, to_a}, {2'b01, 8'h00, 8'hFF})
    req3_chan_a <= 1'b0;
    cyc(4);
    req3_chan_a <= 1'b1;
    req3_chan_b <= 1'b1;
    req2_chan_a <= 1'b1;
    cyc(8);
    `CHK({req3_status, to_a, to_b}, {1'b1, 16'hFFFF})
  endtask : t_req3

  task automatic t_fault;
    @(posedge aclk);
    stuck <= 1'b1;
    cyc(CPM - 4);
    `CHK(fault, 1'b0)
    cyc(12);
    `CHK({fault, to_a, to_b}, {1'b1, 16'h0000})
  endtask : t_fault

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {stuck, mode_sel_0, mode_sel_1} = 3'b000;
    wstrb = 4'hF;
    {req1_chan_a, req1_chan_b, req1_ack, req2_chan_a, req2_chan_b, req2_ack} = 6'h3F;
    {req3_chan_a, req3_chan_b} = 2'b11;
    cyc(3);
    aresetn <= 1'b1;
    t_startup();
    for (int s = 0; s < 8; s++) t_req1(s);
    t_req2();
    t_req3();
    t_fault();
    give_verdict();
  end

  initial begin
    cyc(60000);
    n_fail++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
